// [design/dac_cfg_pkg.sv]
package dac_cfg_pkg;
  localparam logic [7:0] ADDR_FORMAT    = 8'h26;
  localparam logic [7:0] ADDR_DATAPATH  = 8'h27;
  localparam logic [7:0] ADDR_INTERP    = 8'h28;
  localparam logic [7:0] ADDR_THR_LO    = 8'h29;
  localparam logic [7:0] ADDR_THR_HI    = 8'h2A;
  localparam logic [7:0] ADDR_PROTECT   = 8'h2B;
  localparam logic [7:0] ADDR_PWR_LO    = 8'h2C;
  localparam logic [7:0] ADDR_PWR_HI    = 8'h2D;
  localparam logic [7:0] ADDR_OSC       = 8'h30;

  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam logic [7:0] FORMAT_WMASK   = 8'hE1;
  localparam logic [7:0] DATAPATH_WMASK = 8'hF7;
  localparam logic [7:0] INTERP_WMASK   = 8'h03;
  localparam logic [7:0] THR_HI_WMASK   = 8'h1F;
  localparam logic [7:0] PROTECT_WMASK  = 8'hCF;
  localparam logic [7:0] OSC_WMASK      = 8'h11;

  localparam int unsigned FMT_OFFSET_BIN_BIT = 7;
  localparam int unsigned FMT_PAIR_PRIOR_BIT = 6;
  localparam int unsigned FMT_REVERSE_BIT    = 5;
  localparam int unsigned FMT_BYTE_MODE_BIT  = 0;

  localparam int unsigned DP_SINC_BIT    = 7;
  localparam int unsigned DP_MIXER_BIT   = 6;
  localparam int unsigned DP_GAIN_BIT    = 5;
  localparam int unsigned DP_PHASE_BIT   = 4;
  localparam int unsigned DP_QUARTER_BIT = 2;
  localparam int unsigned DP_IMAGE_BIT   = 1;
  localparam int unsigned DP_I_BOTH_BIT  = 0;

  localparam logic [1:0] INTERP_4X = 2'h2;
  localparam logic [1:0] INTERP_8X = 2'h3;

  localparam int unsigned PROT_ENABLE_BIT = 7;
  localparam int unsigned PROT_SWAP_BIT   = 6;
  localparam logic [3:0]  WINDOW_CODE_MAX = 4'hA;

  localparam int unsigned OSC_UPD_REQ_BIT  = 0;
  localparam int unsigned OSC_UPD_DONE_BIT = 1;
  localparam int unsigned OSC_PH_REQ_BIT   = 4;
  localparam int unsigned OSC_PH_DONE_BIT  = 5;
  localparam int unsigned OSC_FRAME_BIT    = 6;

  localparam int unsigned  DATA_WIDTH  = 16;
  localparam int unsigned  BYTE_WIDTH  = 8;
  localparam int unsigned  POWER_WIDTH = 13;
  localparam int unsigned  TUNING_WIDTH = 32;
  localparam logic [15:0]  SIGN_FLIP   = 16'h8000;

  typedef enum logic [3:0] {
    SLOT_I_HIGH = 4'b0001,
    SLOT_I_LOW  = 4'b0010,
    SLOT_Q_HIGH = 4'b0100,
    SLOT_Q_LOW  = 4'b1000
  } slot_t;
endpackage : dac_cfg_pkg

// [design/dac_datapath_config_regs.sv]
// What this block does
// RULE1 - format bit 7: zero means twos complement input, one means offset binary
// RULE2 - pairing bit 6: zero pairs I with next Q, one with prior Q
// RULE3 - bit-reverse bit 5 flips the sixteen data lines end for end
// RULE4 - format bit 0 picks word-wide or byte-wide input; source must match
// RULE5 - datapath bit 7 enables sinc compensation, bit 2 quarter-rate mixing, reset off
// RULE6 - datapath bit 6 enables oscillator mixer, bit 1 picks low or high image
// RULE7 - datapath bit 5 enables gain correction and dc offset, else bypassed
// RULE8 - datapath bit 4 enables quadrature phase correction, else bypassed
// RULE9 - datapath bit 0 sends in-phase data to both outputs, Q discarded
// RULE10 - interpolation field picks 2x, 4x or 8x and the halfband chain
// RULE11 - protection threshold is 13 bits split over two registers
// RULE12 - protection bit 7 enables the over-power protection effect
// RULE13 - protection bit 6 exchanges I and Q in the power computation
// RULE14 - window code sets 512 times two to the code sample pairs
// RULE15 - measured average power reads back as 13 bits over two registers
// RULE16 - bit 0 requests tuning word update, bit 1 reports it done
// RULE17 - bit 4 requests oscillator phase reset, bit 5 acknowledges it
// RULE18 - bit 6 shows the last tuning update came from the frame input
// RULE19 - tuning word takes effect only on an update request, not on writes
// RULE20 - acknowledges hold while request held; software clears request before reissuing
`timescale 1ns/100ps
module dac_datapath_config_regs #(
  parameter int unsigned WINDOW_BASE_LOG2 = 9
) (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_write_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [15:0] data_i,
  input  wire logic        data_valid_i,
  input  wire logic        frame_i,
  input  wire logic [31:0] tuning_word_i,
  output logic      [15:0] sample_i_o,
  output logic      [15:0] sample_q_o,
  output logic             sample_valid_o,
  output logic             sinc_compensation_on_o,
  output logic             oscillator_mixer_on_o,
  output logic             gain_offset_correction_on_o,
  output logic             quadrature_phase_correction_on_o,
  output logic             quarter_rate_mixer_on_o,
  output logic             mixer_image_select_o,
  output logic             first_halfband_filter_on_o,
  output logic             second_halfband_filter_on_o,
  output logic             third_halfband_filter_on_o,
  output logic             power_protect_o,
  output logic      [31:0] active_tuning_word_o,
  output logic             phase_reset_o
);
  localparam int unsigned LOG2_W = 6;
  localparam int unsigned CNT_W  = WINDOW_BASE_LOG2 + 11;
  localparam int unsigned ACC_W  = dac_cfg_pkg::POWER_WIDTH + CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [15:0] data_meta;
  logic [15:0] data_sync;
  logic        valid_meta;
  logic        valid_sync;
  logic        frame_meta;
  logic        frame_sync;
  logic        frame_prev;
  logic        frame_rise;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      data_meta  <= 16'h0000;
      data_sync  <= 16'h0000;
      valid_meta <= 1'b0;
      valid_sync <= 1'b0;
      frame_meta <= 1'b0;
      frame_sync <= 1'b0;
      frame_prev <= 1'b0;
    end else begin
      data_meta  <= data_i;
      data_sync  <= data_meta;
      valid_meta <= data_valid_i;
      valid_sync <= valid_meta;
      frame_meta <= frame_i;
      frame_sync <= frame_meta;
      frame_prev <= frame_sync;
    end
  end
  assign frame_rise = frame_sync & ~frame_prev;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] format_reg;
  logic [7:0] datapath_reg;
  logic [7:0] interp_reg;
  logic [7:0] thr_lo_reg;
  logic [7:0] thr_hi_reg;
  logic [7:0] protect_reg;
  logic [7:0] osc_req_reg;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      format_reg   <= dac_cfg_pkg::RESET_VALUE;
      datapath_reg <= dac_cfg_pkg::RESET_VALUE; // RULE5
      interp_reg   <= dac_cfg_pkg::RESET_VALUE;
      thr_lo_reg   <= dac_cfg_pkg::RESET_VALUE;
      thr_hi_reg   <= dac_cfg_pkg::RESET_VALUE;
      protect_reg  <= dac_cfg_pkg::RESET_VALUE;
      osc_req_reg  <= dac_cfg_pkg::RESET_VALUE;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        dac_cfg_pkg::ADDR_FORMAT:   format_reg   <= reg_wdata_i & dac_cfg_pkg::FORMAT_WMASK;
        dac_cfg_pkg::ADDR_DATAPATH: datapath_reg <= reg_wdata_i & dac_cfg_pkg::DATAPATH_WMASK;
        dac_cfg_pkg::ADDR_INTERP:   interp_reg   <= reg_wdata_i & dac_cfg_pkg::INTERP_WMASK;
        dac_cfg_pkg::ADDR_THR_LO:   thr_lo_reg   <= reg_wdata_i; // RULE11
        dac_cfg_pkg::ADDR_THR_HI:   thr_hi_reg   <= reg_wdata_i & dac_cfg_pkg::THR_HI_WMASK;
        dac_cfg_pkg::ADDR_PROTECT:  protect_reg  <= reg_wdata_i & dac_cfg_pkg::PROTECT_WMASK;
        dac_cfg_pkg::ADDR_OSC:      osc_req_reg  <= reg_wdata_i & dac_cfg_pkg::OSC_WMASK;
        default: ;
      endcase
    end
  end

  assign sinc_compensation_on_o           = datapath_reg[dac_cfg_pkg::DP_SINC_BIT];    // RULE5
  assign quarter_rate_mixer_on_o          = datapath_reg[dac_cfg_pkg::DP_QUARTER_BIT]; // RULE5
  assign oscillator_mixer_on_o            = datapath_reg[dac_cfg_pkg::DP_MIXER_BIT];   // RULE6
  assign mixer_image_select_o             = datapath_reg[dac_cfg_pkg::DP_IMAGE_BIT];   // RULE6
  assign gain_offset_correction_on_o      = datapath_reg[dac_cfg_pkg::DP_GAIN_BIT];    // RULE7
  assign quadrature_phase_correction_on_o = datapath_reg[dac_cfg_pkg::DP_PHASE_BIT];   // RULE8

  // code 01 is undefined; it is treated as 2x
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      first_halfband_filter_on_o  <= 1'b0;
      second_halfband_filter_on_o <= 1'b0;
      third_halfband_filter_on_o  <= 1'b0;
    end else begin
      first_halfband_filter_on_o  <= 1'b1; // RULE10
      second_halfband_filter_on_o <= interp_reg[1]; // RULE10
      third_halfband_filter_on_o  <= interp_reg[1:0] == dac_cfg_pkg::INTERP_8X; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tuning update and phase reset handshakes
  logic upd_req;
  logic upd_prev;
  logic upd_start;
  logic ph_req;
  logic ph_prev;
  logic ph_start;
  logic upd_done_reg;
  logic ph_done_reg;
  logic frame_flag_reg;

  assign upd_req   = osc_req_reg[dac_cfg_pkg::OSC_UPD_REQ_BIT];
  assign ph_req    = osc_req_reg[dac_cfg_pkg::OSC_PH_REQ_BIT];
  assign upd_start = upd_req & ~upd_prev;
  assign ph_start  = ph_req & ~ph_prev;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      upd_prev             <= 1'b0;
      ph_prev              <= 1'b0;
      upd_done_reg         <= 1'b0;
      ph_done_reg          <= 1'b0;
      frame_flag_reg       <= 1'b0;
      phase_reset_o        <= 1'b0;
      active_tuning_word_o <= 32'h0000_0000;
    end else begin
      upd_prev      <= upd_req;
      ph_prev       <= ph_req;
      phase_reset_o <= ph_start; // RULE17
      // staged word passes only on a request edge or a frame edge
      if (upd_start || frame_rise) begin
        active_tuning_word_o <= tuning_word_i; // RULE19
      end
      if (!upd_req) begin
        upd_done_reg <= 1'b0; // RULE20
      end else if (upd_start) begin
        upd_done_reg <= 1'b1; // RULE16
      end
      if (!ph_req) begin
        ph_done_reg <= 1'b0; // RULE20
      end else if (ph_start) begin
        ph_done_reg <= 1'b1; // RULE17
      end
      // frame set wins over a serial update in the same cycle
      if (frame_rise) begin
        frame_flag_reg <= 1'b1; // RULE18
      end else if (upd_start) begin
        frame_flag_reg <= 1'b0; // RULE18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input word assembly
  logic [15:0] reversed;
  logic [15:0] word;
  logic [7:0]  hold_hi;
  logic [15:0] word_val;
  logic        word_done;
  logic        word_is_i;
  logic        byte_mode;
  dac_cfg_pkg::slot_t slot_reg;
  dac_cfg_pkg::slot_t slot_next;

  for (genvar b = 0; b < dac_cfg_pkg::DATA_WIDTH; b++) begin : g_rev
    assign reversed[b] = data_sync[dac_cfg_pkg::DATA_WIDTH - 1 - b]; // RULE3
  end
  assign word      = format_reg[dac_cfg_pkg::FMT_REVERSE_BIT] ? reversed : data_sync; // RULE3
  assign byte_mode = format_reg[dac_cfg_pkg::FMT_BYTE_MODE_BIT]; // RULE4

  always_comb begin
    slot_next = slot_reg;
    word_done = 1'b0;
    word_is_i = 1'b0;
    word_val  = byte_mode ? {hold_hi, word[7:0]} : word;
    case (slot_reg)
      dac_cfg_pkg::SLOT_I_HIGH: if (valid_sync) begin
        word_done = ~byte_mode;
        word_is_i = 1'b1;
        slot_next = byte_mode ? dac_cfg_pkg::SLOT_I_LOW : dac_cfg_pkg::SLOT_Q_HIGH; // RULE4
      end
      dac_cfg_pkg::SLOT_I_LOW: if (valid_sync) begin
        word_done = 1'b1;
        word_is_i = 1'b1;
        slot_next = dac_cfg_pkg::SLOT_Q_HIGH;
      end
      dac_cfg_pkg::SLOT_Q_HIGH: if (valid_sync) begin
        word_done = ~byte_mode;
        slot_next = byte_mode ? dac_cfg_pkg::SLOT_Q_LOW : dac_cfg_pkg::SLOT_I_HIGH; // RULE4
      end
      dac_cfg_pkg::SLOT_Q_LOW: if (valid_sync) begin
        word_done = 1'b1;
        slot_next = dac_cfg_pkg::SLOT_I_HIGH;
      end
      default: slot_next = dac_cfg_pkg::SLOT_I_HIGH;
    endcase
    if (format_reg[dac_cfg_pkg::FMT_OFFSET_BIN_BIT]) begin
      word_val = word_val ^ dac_cfg_pkg::SIGN_FLIP; // RULE1
    end
  end

  // a frame edge realigns the slot to an in-phase high part
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= dac_cfg_pkg::SLOT_I_HIGH;
      hold_hi  <= 8'h00;
    end else begin
      slot_reg <= frame_rise ? dac_cfg_pkg::SLOT_I_HIGH : slot_next;
      if (valid_sync) begin
        hold_hi <= word[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I/Q pairing
  logic [15:0] i_hold;
  logic [15:0] q_hold;
  logic        q_seen;
  logic        pair_prior;
  logic        i_both;

  assign pair_prior = format_reg[dac_cfg_pkg::FMT_PAIR_PRIOR_BIT];
  assign i_both     = datapath_reg[dac_cfg_pkg::DP_I_BOTH_BIT];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      i_hold         <= 16'h0000;
      q_hold         <= 16'h0000;
      q_seen         <= 1'b0;
      sample_i_o     <= 16'h0000;
      sample_q_o     <= 16'h0000;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= 1'b0;
      if (frame_rise) begin
        q_seen <= 1'b0;
      end else if (word_done && word_is_i) begin
        i_hold <= word_val;
        if (pair_prior && q_seen) begin
          sample_i_o     <= word_val; // RULE2
          sample_q_o     <= i_both ? word_val : q_hold; // RULE9
          sample_valid_o <= 1'b1;
        end
      end else if (word_done) begin
        q_hold <= word_val;
        q_seen <= 1'b1;
        if (!pair_prior) begin
          sample_i_o     <= i_hold; // RULE2
          sample_q_o     <= i_both ? i_hold : word_val; // RULE9
          sample_valid_o <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // average power over a window of pairs
  logic signed [7:0]  pow_a;
  logic signed [7:0]  pow_b;
  logic        [16:0] pow_sum;
  logic        [12:0] pow_sample;
  logic [3:0]         win_code;
  logic [LOG2_W-1:0]  win_log2;
  logic [CNT_W-1:0]   win_cnt;
  logic [ACC_W-1:0]   acc;
  logic [ACC_W-1:0]   acc_sum;
  logic [ACC_W-1:0]   acc_avg;
  logic [12:0]        avg_reg;
  logic               win_last;
  logic               win_restart;
  logic [12:0]        threshold;

  // I and Q sit in their own sample registers, so the exchange steers them
  assign pow_a      = protect_reg[dac_cfg_pkg::PROT_SWAP_BIT] ? sample_q_o[15:8]
                                                              : sample_i_o[15:8]; // RULE13
  assign pow_b      = protect_reg[dac_cfg_pkg::PROT_SWAP_BIT] ? sample_i_o[15:8]
                                                              : sample_q_o[15:8]; // RULE13
  assign pow_sum    = 17'(pow_a * pow_a) + 17'(pow_b * pow_b);
  assign pow_sample = pow_sum[15:3];
  // invalid codes clamp to the longest window
  assign win_code   = (protect_reg[3:0] > dac_cfg_pkg::WINDOW_CODE_MAX)
                      ? dac_cfg_pkg::WINDOW_CODE_MAX : protect_reg[3:0]; // RULE14
  assign win_log2   = LOG2_W'(WINDOW_BASE_LOG2) + LOG2_W'(win_code); // RULE14
  assign win_last   = win_cnt == ((CNT_W'(1) << win_log2) - CNT_W'(1)); // RULE14
  assign acc_sum    = acc + ACC_W'(pow_sample);
  assign acc_avg    = acc_sum >> win_log2;
  assign win_restart = reg_write_i && reg_addr_i == dac_cfg_pkg::ADDR_PROTECT;
  assign threshold  = {thr_hi_reg[4:0], thr_lo_reg}; // RULE11

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= '0;
      acc     <= '0;
      avg_reg <= 13'h0000;
    end else if (win_restart) begin
      win_cnt <= '0;
      acc     <= '0;
    end else if (sample_valid_o) begin
      if (win_last) begin
        avg_reg <= acc_avg[12:0]; // RULE15
        acc     <= '0;
        win_cnt <= '0;
      end else begin
        acc     <= acc_sum;
        win_cnt <= win_cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      power_protect_o <= 1'b0;
    end else begin
      power_protect_o <= protect_reg[dac_cfg_pkg::PROT_ENABLE_BIT]
                         && (avg_reg >= threshold); // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back, one cycle after the address
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        dac_cfg_pkg::ADDR_FORMAT:   reg_rdata_o <= format_reg;
        dac_cfg_pkg::ADDR_DATAPATH: reg_rdata_o <= datapath_reg;
        dac_cfg_pkg::ADDR_INTERP:   reg_rdata_o <= interp_reg;
        dac_cfg_pkg::ADDR_THR_LO:   reg_rdata_o <= thr_lo_reg;
        dac_cfg_pkg::ADDR_THR_HI:   reg_rdata_o <= thr_hi_reg;
        dac_cfg_pkg::ADDR_PROTECT:  reg_rdata_o <= protect_reg;
        dac_cfg_pkg::ADDR_PWR_LO:   reg_rdata_o <= avg_reg[7:0]; // RULE15
        dac_cfg_pkg::ADDR_PWR_HI:   reg_rdata_o <= {3'h0, avg_reg[12:8]}; // RULE15
        dac_cfg_pkg::ADDR_OSC:      reg_rdata_o <= {1'b0, frame_flag_reg, ph_done_reg,
                                                    ph_req, 2'h0, upd_done_reg, upd_req};
        default:                    reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_sinc_write;
    @(posedge clock_i) disable iff (!rst_n)
      reg_write_i && reg_addr_i == dac_cfg_pkg::ADDR_DATAPATH
      |=> sinc_compensation_on_o == $past(reg_wdata_i[7]);
  endproperty
  a_sinc_write: assert property (p_sinc_write) else $error("sinc enable not written"); // RULE5

  property p_eight_x;
    @(posedge clock_i) disable iff (!rst_n)
      reg_write_i && reg_addr_i == dac_cfg_pkg::ADDR_INTERP
      |=> ##1 third_halfband_filter_on_o == ($past(reg_wdata_i[1:0], 2) == 2'h3);
  endproperty
  a_eight_x: assert property (p_eight_x) else $error("third halfband wrong"); // RULE10

  property p_chain;
    @(posedge clock_i) disable iff (!rst_n)
      third_halfband_filter_on_o |-> second_halfband_filter_on_o && first_halfband_filter_on_o;
  endproperty
  a_chain: assert property (p_chain) else $error("halfband chain broken"); // RULE10

  property p_protect_gate;
    @(posedge clock_i) disable iff (!rst_n)
      power_protect_o |-> $past(protect_reg[7]) && $past(avg_reg >= threshold);
  endproperty
  a_protect_gate: assert property (p_protect_gate) else $error("protect without cause"); // RULE12

  property p_i_both;
    @(posedge clock_i) disable iff (!rst_n)
      sample_valid_o && $past(i_both) |-> sample_q_o == sample_i_o;
  endproperty
  a_i_both: assert property (p_i_both) else $error("Q output not in-phase copy"); // RULE9

  property p_update;
    @(posedge clock_i) disable iff (!rst_n)
      upd_start |=> upd_done_reg && active_tuning_word_o == $past(tuning_word_i);
  endproperty
  a_update: assert property (p_update) else $error("tuning update not done"); // RULE16

  property p_word_hold;
    @(posedge clock_i) disable iff (!rst_n)
      !upd_start && !frame_rise |=> $stable(active_tuning_word_o);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("tuning word moved"); // RULE19

  property p_phase_pulse;
    @(posedge clock_i) disable iff (!rst_n)
      ph_start |=> phase_reset_o && ph_done_reg ##1 !phase_reset_o;
  endproperty
  a_phase_pulse: assert property (p_phase_pulse) else $error("phase reset pulse wrong"); // RULE17

  property p_frame_flag;
    @(posedge clock_i) disable iff (!rst_n)
      frame_rise |=> frame_flag_reg;
  endproperty
  a_frame_flag: assert property (p_frame_flag) else $error("frame flag not set"); // RULE18

  property p_ack_drop;
    @(posedge clock_i) disable iff (!rst_n)
      !upd_req |=> !upd_done_reg;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("done held without request"); // RULE20

  property p_power_read;
    @(posedge clock_i) disable iff (!rst_n)
      reg_addr_i == dac_cfg_pkg::ADDR_PWR_HI
      |=> reg_rdata_o == {3'h0, $past(avg_reg[12:8])};
  endproperty
  a_power_read: assert property (p_power_read) else $error("power readback wrong"); // RULE15
endmodule : dac_datapath_config_regs

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  logic        clock_i, reset_n_i, reg_write_i, data_valid_i, frame_i, sample_valid_o, ph_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [15:0] data_i, sample_i_o, sample_q_o;
  logic [31:0] tuning_word_i, tw_o;
  wire  [9:0]  fl;
  int          err_count, checks;

  dac_datapath_config_regs #(.WINDOW_BASE_LOG2(2)) DUT (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .data_i(data_i), .data_valid_i(data_valid_i), .frame_i(frame_i),
    .tuning_word_i(tuning_word_i), .sample_i_o(sample_i_o), .sample_q_o(sample_q_o),
    .sample_valid_o(sample_valid_o), .sinc_compensation_on_o(fl[9]),
    .oscillator_mixer_on_o(fl[8]), .gain_offset_correction_on_o(fl[7]),
    .quadrature_phase_correction_on_o(fl[6]), .quarter_rate_mixer_on_o(fl[5]),
    .mixer_image_select_o(fl[4]), .first_halfband_filter_on_o(fl[3]),
    .second_halfband_filter_on_o(fl[2]), .third_halfband_filter_on_o(fl[1]),
    .power_protect_o(fl[0]), .active_tuning_word_o(tw_o), .phase_reset_o(ph_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
    @(posedge clock_i) reg_write_i <= 1'b0;
  endtask : wr

  // one cycle of read latency, no strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i) reg_addr_i <= a;
    @(posedge clock_i);
    #1 chk({24'h0, reg_rdata_o}, {24'h0, e});
  endtask : rdc

  task automatic send(input logic [15:0] w);
    @(posedge clock_i) {data_i, data_valid_i} <= {w, 1'b1};
    @(posedge clock_i) {data_i, data_valid_i} <= {~w, 1'b0};
  endtask : send

  task automatic pair(input logic [15:0] ei, input logic [15:0] eq);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      #1 n++;
    end while (sample_valid_o !== 1'b1 && n < 20);
    chk({31'h0, sample_valid_o}, 32'h1);
    chk({sample_i_o, sample_q_o}, {ei, eq});
  endtask : pair

  // frame pin passes two flops and an edge detector before it realigns
  task automatic pulse_frame();
    @(posedge clock_i) frame_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    frame_i <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask : pulse_frame

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] al[10] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h30,
                           8'h50};
    foreach (al[k]) rdc(al[k], 8'h00);
    chk({22'h0, fl}, 32'h8);
    $display("test reset done");
  endtask : t_reset

  task automatic t_dp();
    wr(8'h27, 8'hF6);
    #1 chk({26'h0, fl[9:4]}, 32'h3F);
    rdc(8'h27, 8'hF6);
    wr(8'h27, 8'hA2);
    #1 chk({26'h0, fl[9:4]}, 32'h29);
    wr(8'h27, 8'h54);
    #1 chk({26'h0, fl[9:4]}, 32'h16);
    wr(8'h27, 8'h00);
    #1 chk({26'h0, fl[9:4]}, 32'h0);
    $display("test datapath done");
  endtask : t_dp

  task automatic t_interp();
    logic [7:0] cd[3] = '{8'h02, 8'h03, 8'h00};
    logic [2:0] hb[3] = '{3'b110, 3'b111, 3'b100};
    foreach (cd[k]) begin
      wr(8'h28, cd[k]);
      @(posedge clock_i);
      #1 chk({29'h0, fl[3:1]}, {29'h0, hb[k]});
    end
    $display("test interpolation done");
  endtask : t_interp

  task automatic t_regs();
    wr(8'h2A, 8'hFF);
    rdc(8'h2A, 8'h1F);
    wr(8'h29, 8'hA5);
    rdc(8'h29, 8'hA5);
    wr(8'h2C, 8'hFF);
    rdc(8'h2C, 8'h00);
    wr(8'h26, 8'hFF);
    rdc(8'h26, 8'hE1);
    wr(8'h26, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_osc();
    chk(tw_o, 32'h0);
    wr(8'h30, 8'h01);
    rdc(8'h30, 8'h03);
    chk(tw_o, 32'h12345678);
    tuning_word_i <= 32'hCAFE0001;
    wr(8'h30, 8'h00);
    rdc(8'h30, 8'h00);
    chk(tw_o, 32'h12345678);
    wr(8'h30, 8'h10);
    @(posedge clock_i);
    #1 chk({31'h0, ph_o}, 32'h1);
    @(posedge clock_i);
    #1 chk({31'h0, ph_o}, 32'h0);
    rdc(8'h30, 8'h30);
    wr(8'h30, 8'h00);
    $display("test oscillator done");
  endtask : t_osc

  // pairing change is only safe after a frame realigns the slots
  task automatic t_data();
    wr(8'h26, 8'h80);
    wr(8'h27, 8'h01);
    send(16'h9234);
    send(16'h0F00);
    pair(16'h1234, 16'h1234);
    wr(8'h27, 8'h00);
    send(16'h8001);
    send(16'h7FFF);
    pair(16'h0001, 16'hFFFF);
    wr(8'h26, 8'h40);
    pulse_frame();
    send(16'h1111);
    send(16'h2222);
    send(16'h3333);
    pair(16'h3333, 16'h2222);
    rdc(8'h30, 8'h40);
    chk(tw_o, 32'hCAFE0001);
    $display("test data path done");
  endtask : t_data

  // follows t_data: pairing to prior Q, slot waiting for a Q word
  task automatic t_power();
    wr(8'h29, 8'h42);
    wr(8'h2A, 8'h02);
    wr(8'h2B, 8'h80);
    for (int k = 0; k < 4; k++) begin
      send(16'h0000);
      send(16'h4400);
      pair(16'h4400, 16'h0000);
      if (k == 2) rdc(8'h2C, 8'h00);
    end
    rdc(8'h2C, 8'h42);
    rdc(8'h2D, 8'h02);
    chk({31'h0, fl[0]}, 32'h1);
    wr(8'h2B, 8'h00);
    @(posedge clock_i);
    #1 chk({31'h0, fl[0]}, 32'h0);
    $display("test power done");
  endtask : t_power

  // bytes arrive bit-reversed on the upper lines, high byte first
  task automatic t_bytes();
    wr(8'h26, 8'h21);
    pulse_frame();
    send(16'h4800);
    send(16'h2C00);
    send(16'h6A00);
    send(16'h1E00);
    pair(16'h1234, 16'h5678);
    wr(8'h26, 8'h00);
    $display("test byte mode done");
  endtask : t_bytes

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // whole run is well under a thousand cycles
  initial begin
    #(40 * 5000);
    err_count++;
    test_done();
  end

  initial begin
    {reset_n_i, reg_write_i, data_valid_i, frame_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, data_i} = 32'h0;
    tuning_word_i = 32'h12345678;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset();
    t_dp();
    t_interp();
    t_regs();
    t_osc();
    t_data();
    t_power();
    t_bytes();
    test_done();
  end
endmodule : tb
